/* common/upsfc_map.vh */
// Constants for the serial-port power-saving and flow-control block.
// Assumes a single 200 MHz clock; every other rate is derived from it.
//
// Summary of operation
// R01: Terminal holds DTR low, or grounds it.
// R02: Hardware flow on: send only while RTS low.
// R03: CTS low only when active, enabled, flow on; code also drives CTS low in mode 2 while RTS is off.
// R04: Three-wire: CTS looped to RTS, others open.
// R05: Cyclic saving: terminal holds data, device receives later.
// R06: Mode 2: RTS falling wakes after 20 ms.
// R07: Mode 2: RTS held low keeps device active.
// R08: TxD rising while idle wakes after 20 ms.
// R09: Character arriving while idle is discarded.
// R10: Terminal sends wake-up character before commands.
// R11: Firmware-upgrade listening only after reset release.
// R12: Multiplexed sessions with flag-delimited framing.
// R13: Channel 0 control, 1-5 data, 6 GPS.
// R14: GPS link enabled: never enter idle.
// R15: Setting 0 never idles; default setting.
// R16: Idle timeout 40..65000 frames, default 2000.
// R17: Each received character restarts the timeout.
// R18: Idle/active machine; idle only on timeout.
`ifndef UPSFC_MAP_VH
`define UPSFC_MAP_VH

// Power-saving settings.
`define UPSFC_PSV_OFF 2'h0
`define UPSFC_PSV_CYCLIC 2'h1
`define UPSFC_PSV_RTS 2'h2

// Timing: clock period, wake-up time and frame length in their own units.
`define UPSFC_CLK_PERIOD_NS 5
`define UPSFC_WAKE_TIME_MS 20
`define UPSFC_GSM_FRAME_US 4615
// Cycle counts sized to their counters: 20 ms and one frame at 5 ns.
`define UPSFC_WAKE_CYC 22'h3d0900
`define UPSFC_FRAME_CYC 20'he1578

// Idle timeout limits and default, in frames.
`define UPSFC_TMO_MIN 16'h0028
`define UPSFC_TMO_MAX 16'hfde8
`define UPSFC_TMO_DEFAULT 16'h07d0

// Multiplexer framing.
`define UPSFC_MUX_FLAG 8'hf9
`define UPSFC_CH_CONTROL 6'h00
`define UPSFC_CH_DATA_FIRST 6'h01
`define UPSFC_CH_DATA_LAST 6'h05
`define UPSFC_CH_GPS 6'h06
`define UPSFC_CLS_CONTROL 2'h0
`define UPSFC_CLS_DATA 2'h1
`define UPSFC_CLS_GPS 2'h2
`define UPSFC_CLS_NONE 2'h3

`endif

/* verilog/upsfc_frame_tick.v */
// Frame-rate tick generator for the idle timeout.
// Assumes the 200 MHz clock; emits a one-cycle pulse every frame.
`timescale 1ns/1ps
`default_nettype none

module upsfc_frame_tick #(
    parameter [19:0] FRAME_CYC = 20'he1578
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire restart_in,
    output reg tick_out
);

    reg [19:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Divider; restart realigns the frame phase to the last character.
    always @(posedge clk_in) begin
        if (!rst_n_in || restart_in) begin
            cnt_r <= 20'h00000;
            tick_out <= 1'b0;
        end else if (cnt_r == FRAME_CYC - 20'h00001) begin
            cnt_r <= 20'h00000;
            tick_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 20'h00001;
            tick_out <= 1'b0;
        end
    end

endmodule // upsfc_frame_tick

`default_nettype wire

/* verilog/upsfc_mux_parse.v */
// Multiplexer frame parser for bytes received from the terminal.
// Assumes whole received bytes arrive as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "upsfc_map.vh"

module upsfc_mux_parse (
    input wire clk_in,
    input wire rst_n_in,
    input wire byte_valid_in,
    input wire [7:0] byte_in,
    output reg data_valid_out,
    output reg [7:0] data_out,
    output reg [5:0] dlci_out,
    output reg [1:0] chan_class_out
);

    localparam [2:0] ST_HUNT = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_CTRL = 3'h2;
    localparam [2:0] ST_LEN = 3'h3;
    localparam [2:0] ST_DATA = 3'h4;
    localparam [2:0] ST_FCS = 3'h5;

    reg [2:0] state_r;
    reg [6:0] left_r;

    // Maps a channel number to its use.
    function [1:0] chan_class;
        input [5:0] dlci;
        begin
            if (dlci == `UPSFC_CH_CONTROL)
                chan_class = `UPSFC_CLS_CONTROL;
            else if (dlci >= `UPSFC_CH_DATA_FIRST && dlci <= `UPSFC_CH_DATA_LAST)
                chan_class = `UPSFC_CLS_DATA;
            else if (dlci == `UPSFC_CH_GPS)
                chan_class = `UPSFC_CLS_GPS;
            else
                chan_class = `UPSFC_CLS_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Frame walk: flag, address, control, length, payload, check, flag.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_HUNT;
            left_r <= 7'h00;
            data_valid_out <= 1'b0;
            data_out <= 8'h00;
            dlci_out <= 6'h00;
            chan_class_out <= `UPSFC_CLS_NONE;
        end else begin
            data_valid_out <= 1'b0;
            if (byte_valid_in) begin
                case (state_r)
                    ST_HUNT: begin
                        if (byte_in == `UPSFC_MUX_FLAG) begin
                            state_r <= ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        if (byte_in != `UPSFC_MUX_FLAG) begin
                            dlci_out <= byte_in[7:2]; // R12
                            chan_class_out <= chan_class(byte_in[7:2]); // R13
                            state_r <= ST_CTRL;
                        end
                    end
                    ST_CTRL: begin
                        state_r <= ST_LEN;
                    end
                    ST_LEN: begin
                        left_r <= byte_in[7:1];
                        state_r <= (byte_in[7:1] == 7'h00) ? ST_FCS : ST_DATA;
                    end
                    ST_DATA: begin
                        data_valid_out <= (chan_class_out != `UPSFC_CLS_NONE); // R13
                        data_out <= byte_in;
                        left_r <= left_r - 7'h01;
                        if (left_r == 7'h01) begin
                            state_r <= ST_FCS;
                        end
                    end
                    ST_FCS: begin
                        state_r <= ST_HUNT;
                    end
                    default: begin
                        state_r <= ST_HUNT;
                    end
                endcase
            end
        end
    end

endmodule // upsfc_mux_parse

`default_nettype wire

/* verilog/upsfc_top.v */
// Serial-port power-saving and flow-control logic of the modem side.
// Assumes all inputs synchronous to clk_in; lines are active-low levels.
`timescale 1ns/1ps
`default_nettype none
`include "upsfc_map.vh"

module upsfc_top #(
    parameter [21:0] WAKE_CYC = `UPSFC_WAKE_CYC,
    parameter [19:0] FRAME_CYC = `UPSFC_FRAME_CYC
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [1:0] power_saving_setting_command_in,
    input wire flow_control_on_setting_in,
    input wire [15:0] idle_timeout_frames_in,
    input wire gps_link_enable_command_in,
    input wire uart_init_done_in,
    input wire paging_wake_in,
    input wire rts_n_in,
    input wire dtr_n_in,
    input wire txd_in,
    input wire rx_byte_valid_in,
    input wire [7:0] rx_byte_in,
    output reg cts_n_out,
    output reg active_out,
    output reg tx_permit_out,
    output reg rx_valid_out,
    output reg [7:0] rx_byte_out,
    output reg fw_upgrade_listen_out,
    output reg dtr_fault_out,
    output reg mux_valid_out,
    output reg [7:0] mux_byte_out,
    output reg [5:0] mux_dlci_out,
    output reg [1:0] mux_class_out
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAKING = 2'h1;
    localparam [1:0] ST_ACTIVE = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [21:0] wake_cnt_r;
    reg [15:0] tmo_cnt_r;
    reg rts_n_prev_r;
    reg txd_prev_r;
    reg init_seen_r;
    wire frame_tick;
    wire rx_in_active;
    wire force_active;
    wire flow_on;
    wire rts_fall;
    wire txd_rise;
    wire tmo_expired;
    wire [15:0] tmo_limit;
    wire mux_valid;
    wire [7:0] mux_byte;
    wire [5:0] mux_dlci;
    wire [1:0] mux_class;

    ////////////////////////////////////////////////////////////////////////
    // Configuration decode.

    // Flow control cannot be on together with the RTS-controlled setting.
    assign flow_on = flow_control_on_setting_in &&
                     (power_saving_setting_command_in != `UPSFC_PSV_RTS);

    // Conditions that forbid idle: setting 0, GPS link, RTS held low in mode 2.
    assign force_active = (power_saving_setting_command_in == `UPSFC_PSV_OFF) || // R15
                          gps_link_enable_command_in || // R14
                          ((power_saving_setting_command_in == `UPSFC_PSV_RTS) &&
                           !rts_n_in); // R07

    // Timeout limit clamped into its programmable range.
    assign tmo_limit = (idle_timeout_frames_in < `UPSFC_TMO_MIN) ? `UPSFC_TMO_MIN :
                       (idle_timeout_frames_in > `UPSFC_TMO_MAX) ? `UPSFC_TMO_MAX :
                       idle_timeout_frames_in; // R16

    assign tmo_expired = (tmo_cnt_r >= tmo_limit);

    // Line edges: RTS going on in mode 2, TxD rising as a wake character.
    assign rts_fall = rts_n_prev_r && !rts_n_in &&
                      (power_saving_setting_command_in == `UPSFC_PSV_RTS); // R06
    assign txd_rise = !txd_prev_r && txd_in; // R08

    // A character counts only once the wake-up time is over.
    assign rx_in_active = rx_byte_valid_in && (state_r == ST_ACTIVE); // R09

    ////////////////////////////////////////////////////////////////////////
    // Edge history of the wake lines.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rts_n_prev_r <= 1'b1;
            txd_prev_r <= 1'b1;
        end else begin
            rts_n_prev_r <= rts_n_in;
            txd_prev_r <= txd_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame tick; each accepted character realigns it.
    upsfc_frame_tick #(
        .FRAME_CYC(FRAME_CYC)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(rx_in_active),
        .tick_out(frame_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Idle/active next-state logic.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (force_active && !rts_fall) begin
                    state_nxt = ST_ACTIVE; // R18
                end else if (rts_fall || txd_rise) begin
                    state_nxt = ST_WAKING; // R06 R08
                end else if (paging_wake_in) begin
                    state_nxt = ST_ACTIVE; // R18
                end
            end
            ST_WAKING: begin
                if (wake_cnt_r == WAKE_CYC - 22'h000001) begin
                    state_nxt = ST_ACTIVE; // R06 R08
                end
            end
            ST_ACTIVE: begin
                if (!force_active && tmo_expired) begin
                    state_nxt = ST_IDLE; // R18
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset lands in active so setting 0 holds from start.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up timer: counts the 20 ms from the wake edge.
    always @(posedge clk_in) begin
        if (!rst_n_in || state_r != ST_WAKING) begin
            wake_cnt_r <= 22'h000000;
        end else begin
            wake_cnt_r <= wake_cnt_r + 22'h000001; // R06 R08
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle timeout in frames; cleared on entry and on every character.
    always @(posedge clk_in) begin
        if (!rst_n_in || state_r != ST_ACTIVE || rx_in_active) begin
            tmo_cnt_r <= 16'h0000; // R17
        end else if (frame_tick && !tmo_expired) begin
            tmo_cnt_r <= tmo_cnt_r + 16'h0001; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake outputs.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cts_n_out <= 1'b1;
            active_out <= 1'b0;
            tx_permit_out <= 1'b0;
            dtr_fault_out <= 1'b0;
        end else begin
            active_out <= (state_nxt == ST_ACTIVE);
            // Also shown when RTS is off in mode 2, as the cyclic case does.
            cts_n_out <= !((state_nxt == ST_ACTIVE) && uart_init_done_in &&
                           (flow_on || ((power_saving_setting_command_in ==
                                         `UPSFC_PSV_RTS) && rts_n_in))); // R03 R15
            tx_permit_out <= (state_nxt == ST_ACTIVE) && uart_init_done_in &&
                             (!flow_on || !rts_n_in); // R02
            dtr_fault_out <= dtr_n_in; // R01
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Received data delivery; idle and waking characters are dropped.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_valid_out <= 1'b0;
            rx_byte_out <= 8'h00;
        end else begin
            rx_valid_out <= rx_in_active && uart_init_done_in; // R05 R09
            if (rx_in_active) begin
                rx_byte_out <= rx_byte_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Firmware-upgrade window: opens only at reset release, shuts at init.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            init_seen_r <= 1'b0;
            fw_upgrade_listen_out <= 1'b0;
        end else begin
            if (uart_init_done_in) begin
                init_seen_r <= 1'b1;
            end
            fw_upgrade_listen_out <= !init_seen_r && !uart_init_done_in; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiplexer session parser on accepted bytes.
    upsfc_mux_parse u_mux (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .byte_valid_in(rx_in_active && uart_init_done_in),
        .byte_in(rx_byte_in),
        .data_valid_out(mux_valid),
        .data_out(mux_byte),
        .dlci_out(mux_dlci),
        .chan_class_out(mux_class)
    );

    // Registered copies so every output leaves from a flip-flop here.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            mux_valid_out <= 1'b0;
            mux_byte_out <= 8'h00;
            mux_dlci_out <= 6'h00;
            mux_class_out <= `UPSFC_CLS_NONE;
        end else begin
            mux_valid_out <= mux_valid; // R12
            mux_byte_out <= mux_byte;
            mux_dlci_out <= mux_dlci;
            mux_class_out <= mux_class; // R13
        end
    end

endmodule // upsfc_top

`default_nettype wire

/* tb/upsfc_assertions.sv */
// Checker for the serial power-saving block, bound to its top ports.
// Assumes the bench shortens WAKE_CYC and FRAME_CYC to small values.
`timescale 1ns/1ps
`default_nettype none
`include "upsfc_map.vh"
module upsfc_assertions #(
    parameter [21:0] WAKE_CYC = 22'h000014,
    parameter [19:0] FRAME_CYC = 20'h0000a
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [1:0] power_saving_setting_command_in,
    input wire flow_control_on_setting_in,
    input wire [15:0] idle_timeout_frames_in,
    input wire gps_link_enable_command_in,
    input wire uart_init_done_in,
    input wire paging_wake_in,
    input wire rts_n_in,
    input wire txd_in,
    input wire rx_byte_valid_in,
    input wire [7:0] rx_byte_in,
    input wire cts_n_out,
    input wire active_out,
    input wire tx_permit_out,
    input wire rx_valid_out,
    input wire [7:0] rx_byte_out,
    input wire fw_upgrade_listen_out,
    input wire mux_valid_out,
    input wire [5:0] mux_dlci_out,
    input wire [1:0] mux_class_out
);
    localparam int WLO = WAKE_CYC - 7;
    localparam int WHI = WAKE_CYC - 5;
    wire [15:0] lim;
    wire [31:0] span;
    reg [31:0] quiet_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Clamp the timeout to its legal range and scale it to clock cycles.
    assign lim = (idle_timeout_frames_in < `UPSFC_TMO_MIN) ? `UPSFC_TMO_MIN :
        (idle_timeout_frames_in > `UPSFC_TMO_MAX) ? `UPSFC_TMO_MAX : idle_timeout_frames_in;
    assign span = lim * FRAME_CYC;
    // Count quiet active cycles since the last byte or the last wake.
    always @(posedge clk_in) begin
        if (!rst_n_in || rx_byte_valid_in || !active_out) begin
            quiet_r <= 32'h0;
        end else begin
            quiet_r <= quiet_r + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_cts_active; !cts_n_out |-> active_out; endproperty
    a_cts_active: assert property (p_cts_active) else $error("cts low while idle");
    property p_rx_cause; rx_valid_out |-> $past(rx_byte_valid_in) && $past(active_out); endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("byte delivered without cause");
    property p_rx_lat;
        rx_byte_valid_in && active_out && uart_init_done_in |=>
            rx_valid_out && rx_byte_out == $past(rx_byte_in);
    endproperty
    a_rx_lat: assert property (p_rx_lat) else $error("active byte not delivered");
    property p_force_off;
        $past(rst_n_in) && $past(power_saving_setting_command_in) == 2'h0 &&
            $past(power_saving_setting_command_in, 2) == 2'h0 |-> active_out;
    endproperty
    a_force_off: assert property (p_force_off) else $error("idle in setting zero");
    property p_gps; gps_link_enable_command_in [*2] |=> active_out; endproperty
    a_gps: assert property (p_gps) else $error("idle with gps link on");
    property p_rts_hold;
        power_saving_setting_command_in == 2'h2 && !rts_n_in && active_out |=> active_out;
    endproperty
    a_rts_hold: assert property (p_rts_hold) else $error("idle with rts held on");
    property p_wake;
        !active_out && $rose(txd_in) && power_saving_setting_command_in != 2'h0 &&
            !gps_link_enable_command_in && !paging_wake_in && rts_n_in |=>
            (!active_out) [*8] ##[WLO:WHI] active_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wake time wrong");
    property p_tmo;
        $fell(active_out) |-> quiet_r + 32'h3 >= span && quiet_r <= span + FRAME_CYC + 32'h3;
    endproperty
    a_tmo: assert property (p_tmo) else $error("idle entered at wrong time");
    property p_fw_open; $rose(fw_upgrade_listen_out) |-> !$past(rst_n_in, 2); endproperty
    a_fw_open: assert property (p_fw_open) else $error("upgrade window opened late");
    property p_fw_close;
        fw_upgrade_listen_out && uart_init_done_in |-> ##[1:2] !fw_upgrade_listen_out;
    endproperty
    a_fw_close: assert property (p_fw_close) else $error("upgrade window stays open");
    property p_mux;
        mux_valid_out |-> mux_class_out == ((mux_dlci_out == 6'h00) ? 2'h0 :
            (mux_dlci_out <= 6'h05) ? 2'h1 : (mux_dlci_out == 6'h06) ? 2'h2 : 2'h3) &&
            mux_class_out != 2'h3;
    endproperty
    a_mux: assert property (p_mux) else $error("bad channel class");
    property p_permit;
        tx_permit_out && $past(flow_control_on_setting_in) &&
            $past(power_saving_setting_command_in) != 2'h2 |-> !$past(rts_n_in);
    endproperty
    a_permit: assert property (p_permit) else $error("send permitted with rts off");
endmodule // upsfc_assertions
`default_nettype wire

/* tb/upsfc_dte_model.sv */
// Terminal-side model: keeps DTR on and hands bytes to the block.
// Assumes the bench pulses req_in for one cycle per byte.
`timescale 1ns/1ps
`default_nettype none
module upsfc_dte_model (
    input wire logic clk_in,
    input wire logic cts_n_in,
    input wire logic hold_in,
    input wire logic req_in,
    input wire logic [7:0] byte_in,
    output logic dtr_n_out,
    output logic valid_out = 1'b0,
    output logic [7:0] data_out = 8'h00,
    output logic pend_out = 1'b0
);
    logic [7:0] buf_r = 8'h00;
    // DTR is held asserted low for the whole run.
    assign dtr_n_out = 1'b0;
    // A byte waits while hold is set and CTS is off; idle data toggles.
    always @(posedge clk_in) begin
        valid_out <= 1'b0;
        data_out <= ~data_out;
        if (req_in) begin
            buf_r <= byte_in;
            pend_out <= 1'b1;
        end else if (pend_out && !(hold_in && cts_n_in)) begin
            valid_out <= 1'b1;
            data_out <= buf_r;
            pend_out <= 1'b0;
        end
    end
endmodule // upsfc_dte_model
`default_nettype wire

/* tb/upsfc_top_bench.sv */
// Self-checking bench for the serial power-saving block.
// Assumes the terminal model feeds bytes; wake and frame counts are shortened.
`timescale 1ns/1ps
`default_nettype none
`include "upsfc_map.vh"
module upsfc_top_bench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic flow = 1'b1, gps = 1'b0, init = 1'b0, page = 1'b0;
    logic rts_n = 1'b1, txd = 1'b0, hold = 1'b1, req = 1'b0;
    logic [1:0] psv = 2'h0, last_mc = 2'h3;
    logic [13:0] last_mux = 14'h0000;
    logic [15:0] tmo = 16'h0000;
    logic [7:0] tx_b = 8'h00, got_rx = 8'h00;
    wire dtr_n, rxv, pend, cts_n, act, permit, rvo, fw, dflt, mv;
    wire [7:0] rxb, rbo, mb;
    wire [5:0] md;
    wire [1:0] mc;
    integer errors = 0, checks = 0, rx_n = 0, mux_n = 0, i, k, n;
    upsfc_top #(.WAKE_CYC(22'h000014), .FRAME_CYC(20'h0000a)) u_upsfc_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .power_saving_setting_command_in(psv),
        .flow_control_on_setting_in(flow), .idle_timeout_frames_in(tmo),
        .gps_link_enable_command_in(gps), .uart_init_done_in(init), .paging_wake_in(page),
        .rts_n_in(rts_n), .dtr_n_in(dtr_n), .txd_in(txd), .rx_byte_valid_in(rxv),
        .rx_byte_in(rxb), .cts_n_out(cts_n), .active_out(act), .tx_permit_out(permit),
        .rx_valid_out(rvo), .rx_byte_out(rbo), .fw_upgrade_listen_out(fw),
        .dtr_fault_out(dflt), .mux_valid_out(mv), .mux_byte_out(mb), .mux_dlci_out(md),
        .mux_class_out(mc));
    upsfc_dte_model u_upsfc_dte_model (.clk_in(clk_in), .cts_n_in(cts_n), .hold_in(hold),
        .req_in(req), .byte_in(tx_b), .dtr_n_out(dtr_n), .valid_out(rxv), .data_out(rxb),
        .pend_out(pend));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // Record delivered bytes and multiplexer payloads.
    always @(posedge clk_in) begin
        if (rvo === 1'b1) begin
            got_rx <= rbo;
            rx_n <= rx_n + 1;
        end
        if (mv === 1'b1) begin
            last_mc <= mc;
            last_mux <= {md, mb};
            mux_n <= mux_n + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input integer c);
        repeat (c) @(posedge clk_in);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Hand one byte to the model and wait until it has gone out.
    task automatic sendb(input logic [7:0] b);
        req <= 1'b1;
        tx_b <= b;
        cyc(1);
        req <= 1'b0;
        n = 0;
        do begin
            cyc(1);
            n = n + 1;
        end while (pend && n < 3000);
    endtask
    // Send one frame with a single payload byte on channel d.
    task automatic frame(input logic [5:0] d, input logic [1:0] cls);
        k = mux_n;
        sendb(`UPSFC_MUX_FLAG);
        sendb({d, 2'h3});
        sendb(8'hef);
        sendb(8'h03);
        sendb({2'h2, d});
        sendb(8'h00);
        cyc(4);
        chk(mux_n - k, (cls == 2'h3) ? 0 : 1);
        if (cls != 2'h3) chk({last_mux, last_mc}, {d, 2'h2, d, cls});
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        cyc(8);
        rst_n_in <= 1'b1;
        cyc(2);
        chk(fw, 1'b1);
        chk(dflt, 1'b0);
        chk(cts_n, 1'b1);
        init <= 1'b1;
        cyc(3);
        chk(fw, 1'b0);
        chk(cts_n, 1'b0);
        sendb(8'h5a);
        psv <= 2'h1;
        cyc(3);
        chk(got_rx, 8'h5a);
        $display("test reset done");
        cyc(387);
        chk(act, 1'b1);
        cyc(20);
        chk(act, 1'b0);
        chk(cts_n, 1'b1);
        req <= 1'b1;
        tx_b <= 8'h3c;
        cyc(1);
        req <= 1'b0;
        cyc(30);
        chk(pend, 1'b1);
        page <= 1'b1;
        cyc(1);
        page <= 1'b0;
        cyc(8);
        chk(got_rx, 8'h3c);
        $display("test cyclic done");
        flow <= 1'b0;
        hold <= 1'b0;
        cyc(420);
        chk(act, 1'b0);
        k = rx_n;
        txd <= 1'b1;
        req <= 1'b1;
        tx_b <= 8'h77;
        cyc(1);
        req <= 1'b0;
        cyc(10);
        chk(act, 1'b0);
        chk(rx_n - k, 0);
        cyc(15);
        chk(act, 1'b1);
        txd <= 1'b0;
        sendb(8'h42);
        cyc(3);
        chk(got_rx, 8'h42);
        $display("test txd wake done");
        psv <= 2'h2;
        cyc(420);
        chk(act, 1'b0);
        rts_n <= 1'b0;
        cyc(10);
        chk(act, 1'b0);
        cyc(15);
        chk(act, 1'b1);
        cyc(500);
        chk(act, 1'b1);
        psv <= 2'h0;
        flow <= 1'b1;
        rts_n <= 1'b1;
        cyc(3);
        chk(permit, 1'b0);
        rts_n <= 1'b0;
        cyc(3);
        chk(permit, 1'b1);
        $display("test rts control done");
        psv <= 2'h1;
        gps <= 1'b1;
        rts_n <= 1'b1;
        tmo <= 16'h002d;
        cyc(500);
        chk(act, 1'b1);
        sendb(8'h01);
        gps <= 1'b0;
        for (i = 0; i < 3; i++) begin
            cyc(300);
            sendb(i[7:0]);
        end
        chk(act, 1'b1);
        cyc(440);
        chk(act, 1'b1);
        cyc(20);
        chk(act, 1'b0);
        $display("test timeout done");
        psv <= 2'h0;
        cyc(3);
        for (i = 0; i < 8; i++) begin
            frame(i[5:0], (i == 0) ? 2'h0 : (i <= 5) ? 2'h1 : (i == 6) ? 2'h2 : 2'h3);
        end
        rts_n <= cts_n;
        cyc(3);
        chk(permit, 1'b1);
        $display("test mux done");
        end_of_test;
    end
    // Cut a hung run short.
    initial begin
        repeat (20000) @(posedge clk_in);
        errors = errors + 1;
        end_of_test;
    end
endmodule // upsfc_top_bench
bind upsfc_top upsfc_assertions #(.WAKE_CYC(WAKE_CYC), .FRAME_CYC(FRAME_CYC))
    u_upsfc_assertions (.*);
`default_nettype wire
